// ==== pd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Port checks of the power-down sequencer
module pd_assertions #(
    parameter int PORT_WIDTH = 8
) (
    // Clock, reset, core write
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire pd_pkg::sfr_write_t SFR_WR,
    input wire logic INSTR_DONE,
    // Outputs watched
    input wire logic OSC_ENABLE,
    input wire logic OSC_FEEDBACK_OPEN,
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic [7:0] POWER_CONTROL,
    input wire logic [7:0] STACK_PTR,
    input wire logic [PORT_WIDTH-1:0] PORT_OUT,
    input wire logic RAM_RETAIN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // Retired control write while running; idle stalls the core, so no write lands there
    wire logic cw = SFR_WR.strobe && SFR_WR.addr == pd_pkg::PWR_CTRL_ADDR
        && INSTR_DONE && CPU_CLK_EN;
    AST_ENTER: assert property (cw && SFR_WR.data[1] |=> !OSC_ENABLE && !CPU_CLK_EN)
        else $error("no power-down");
    AST_CTL: assert property (cw |=> POWER_CONTROL[1:0] == $past(SFR_WR.data[1:0]))
        else $error("control bits");
    AST_FB: assert property (OSC_FEEDBACK_OPEN == !OSC_ENABLE)
        else $error("feedback");
    AST_STAY: assert property (!OSC_ENABLE |=> !OSC_ENABLE && !CPU_CLK_EN)
        else $error("left power-down");
    AST_HOLD: assert property (!OSC_ENABLE |=> $stable(PORT_OUT) && $stable(STACK_PTR))
        else $error("state changed");
    AST_CLK: assert property (PERIPH_CLK_EN == OSC_ENABLE)
        else $error("clock gate");
    AST_RAM: assert property (RAM_RETAIN)
        else $error("ram");
    // Reset values must appear even while reset is still high
    AST_RST: assert property (disable iff (1'h0)
        RESET |=> OSC_ENABLE && STACK_PTR == pd_pkg::STACK_PTR_RESET
        && POWER_CONTROL == pd_pkg::PWR_CTRL_RESET && &PORT_OUT)
        else $error("reset values");
endmodule
bind power_down_sequencer pd_assertions #(.PORT_WIDTH(PORT_WIDTH)) i_chk (.*);
`default_nettype wire

// ==== pd_pkg.sv ====
package pd_pkg;

    // ==========================================================
    // Power control register layout
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam int IDLE_BIT_POS = 0;
    localparam int POWER_DOWN_BIT_POS = 1;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;

    // ==========================================================
    // Reset values of the special function registers
    localparam logic [7:0] SFR_RESET = 8'h00;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
    localparam logic [7:0] STACK_PTR_RESET = 8'h07;
    localparam logic [7:0] STACK_PTR_ADDR = 8'h81;

    // ==========================================================
    // Timing: reset hold and oscillator restart
    localparam int RESET_HOLD_PERIODS = 30;
    localparam int OSC_SETTLE_MS = 10;
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================================
    // Operating mode
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_POWER_DOWN = 2'b11
    } mode_t;

    // Write from the core into the special function register space
    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } sfr_write_t;

endpackage

// ==== power_down_sequencer.sv ====
// Contract
// R1: Setting instruction is last one executed
// R2: Power-down stops the oscillator
// R3: RAM and registers held in power-down
// R4: Port pins keep driving latch values
// R5: Only hardware reset leaves power-down
// R6: Reset clears registers, spares RAM
// R7: Reset frees the oscillator again
// R8: Reset held until oscillator stable; reset_src holds a fixed 40 periods, not the settle time
// R9: Power-down bit opens oscillator feedback
// R10: Internal clock taken from oscillator output
// R11: Reset held at least 30 periods
// R12: Control register at 87h, idle bit 0
// R13: Reset zeros registers, ports ff, stack 07
// R14: Both bits set means power-down wins
`timescale 1ns/1ps
`default_nettype none

module power_down_sequencer #(
    parameter int PORT_WIDTH = 8
) (
    // Clock taken from the oscillator output pin, and reset pin
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Core register write and instruction retire
    input wire pd_pkg::sfr_write_t SFR_WR,
    input wire logic INSTR_DONE,
    input wire logic INTERRUPT,
    // Port latch writes from the core
    input wire logic PORT_WR,
    input wire logic [PORT_WIDTH-1:0] PORT_WR_DATA,
    // Oscillator control
    output logic OSC_ENABLE,
    output logic OSC_FEEDBACK_OPEN,
    // Clock gates and status
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic [7:0] POWER_CONTROL,
    output logic [7:0] STACK_PTR,
    output logic [PORT_WIDTH-1:0] PORT_OUT,
    output logic RAM_RETAIN
);

    // ==========================================================
    // Decode of the control register write
    logic power_control_register_wr;
    logic sp_wr;
    logic wr_pd;
    logic wr_idle;
    logic [7:0] power_control_reg;
    logic [7:0] power_control_next;
    logic [7:0] stack_ptr_reg;
    logic [PORT_WIDTH-1:0] port_latch_reg;
    pd_pkg::mode_t mode_reg;
    pd_pkg::mode_t mode_next;
    logic cpu_en_reg;
    logic periph_en_reg;
    logic osc_en_reg;
    logic fb_open_reg;
    logic retain_reg;
    logic frozen;
    logic enter_pd;
    logic enter_idle;
    logic pd_next;
    logic run_next;
    logic sp_load;
    logic port_load;

    // ==========================================================
    // Power-down test on a mode value; shared by the freeze and next-state views
    function automatic logic is_power_down(input pd_pkg::mode_t mode_value);
        return (mode_value == pd_pkg::MODE_POWER_DOWN);
    endfunction

    // R12: register at 87h
    assign power_control_register_wr = SFR_WR.strobe && (SFR_WR.addr == pd_pkg::PWR_CTRL_ADDR);
    assign sp_wr = SFR_WR.strobe && (SFR_WR.addr == pd_pkg::STACK_PTR_ADDR);
    assign wr_pd = SFR_WR.data[pd_pkg::POWER_DOWN_BIT_POS];
    assign wr_idle = SFR_WR.data[pd_pkg::IDLE_BIT_POS];
    assign frozen = is_power_down(mode_reg);

    // Mode requests count only when the writing instruction retires,
    // so the core never starts a further instruction before the stop
    // R1: entry waits for retire
    assign enter_pd = power_control_register_wr && INSTR_DONE && wr_pd;
    // R14: power-down masks idle
    assign enter_idle = power_control_register_wr && INSTR_DONE && wr_idle && !wr_pd;
    // Next-state views shared by the oscillator and clock gate flops
    assign pd_next = is_power_down(mode_next);
    assign run_next = (mode_next == pd_pkg::MODE_RUN);
    // R3: no register load while frozen
    assign sp_load = sp_wr && !frozen;
    // R4: latches hold while frozen
    assign port_load = PORT_WR && !frozen;

    // ==========================================================
    // Mode selection; the register write lands at once, the mode change only as the instruction retires
    always_comb begin
        mode_next = mode_reg;
        power_control_next = power_control_reg;
        case (mode_reg)
            pd_pkg::MODE_RUN: begin
                if (power_control_register_wr) begin
                    power_control_next = SFR_WR.data;
                end
                // R1: last instruction retires first
                // R14: power-down beats idle
                if (enter_pd) begin
                    mode_next = pd_pkg::MODE_POWER_DOWN;
                end else if (enter_idle) begin
                    mode_next = pd_pkg::MODE_IDLE;
                end
            end
            pd_pkg::MODE_IDLE: begin
                // An interrupt clears the idle bit and resumes the core
                if (INTERRUPT) begin
                    mode_next = pd_pkg::MODE_RUN;
                    power_control_next[pd_pkg::IDLE_BIT_POS] = 1'b0;
                end
            end
            pd_pkg::MODE_POWER_DOWN: begin
                // R5: interrupts ignored here
                mode_next = pd_pkg::MODE_POWER_DOWN;
            end
            default: begin
                mode_next = pd_pkg::MODE_RUN;
            end
        endcase
    end

    // ==========================================================
    // Mode and control register; a synchronous reset is enough because
    // the reset that ends power-down also restarts the clock
    // R6: registers reinitialised
    // R11: reset sampled on clock edges
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mode_reg <= pd_pkg::MODE_RUN;
            power_control_reg <= pd_pkg::PWR_CTRL_RESET;
        end else begin
            mode_reg <= mode_next;
            power_control_reg <= power_control_next;
        end
    end

    // ==========================================================
    // Stack pointer; loads are dropped while frozen
    // R13: stack pointer reset value
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            stack_ptr_reg <= pd_pkg::STACK_PTR_RESET;
        end else if (sp_load) begin
            stack_ptr_reg <= SFR_WR.data;
        end
    end

    // ==========================================================
    // Port latches; the pins follow them through power-down
    // R13: latches reset to ones
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            port_latch_reg <= {PORT_WIDTH{1'b1}};
        end else if (port_load) begin
            port_latch_reg <= PORT_WR_DATA;
        end
    end

    // ==========================================================
    // Oscillator control, from the next mode so the stop comes one cycle
    // after the retiring write and not a cycle later
    // R7: oscillator freed by reset
    // R2: oscillator stopped
    // R9: feedback opened while set
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            osc_en_reg <= 1'b1;
            fb_open_reg <= 1'b0;
        end else begin
            osc_en_reg <= !pd_next;
            fb_open_reg <= pd_next;
        end
    end

    // ==========================================================
    // Clock gates: the core runs only in run, peripherals stop in power-down
    // R2: clocked functions halted
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cpu_en_reg <= 1'b1;
            periph_en_reg <= 1'b1;
        end else begin
            cpu_en_reg <= run_next;
            periph_en_reg <= !pd_next;
        end
    end

    // ==========================================================
    // Memory retention; kept as a flop so every output leaves a register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            retain_reg <= 1'b1;
        end else begin
            retain_reg <= 1'b1;
        end
    end

    // ==========================================================
    // R10: all logic on oscillator clock
    assign OSC_ENABLE = osc_en_reg;
    assign OSC_FEEDBACK_OPEN = fb_open_reg;
    assign CPU_CLK_EN = cpu_en_reg;
    assign PERIPH_CLK_EN = periph_en_reg;
    assign POWER_CONTROL = power_control_reg;
    assign STACK_PTR = stack_ptr_reg;
    assign PORT_OUT = port_latch_reg;
    // RAM is never cleared by this block, so it survives reset
    assign RAM_RETAIN = retain_reg;

endmodule
`default_nettype wire

// ==== reset_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// External reset source: stretches a request into a long reset
module reset_src #(
    parameter int HOLD = 40
) (
    // Clock and request
    input wire logic SYS_CLK,
    input wire logic REQ,
    // Reset to the device
    output logic RESET
);
    int cnt = 0;
    // long reset hold
    // 40 periods covers the minimum; settle time is scaled down to keep runs short
    always @(posedge SYS_CLK) begin
        cnt <= REQ ? HOLD : cnt - (cnt > 0);
    end
    assign RESET = cnt > 0;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Bench with a behavioural model of mode and registers
module tb_top;
    logic clk = 0, rst = 1, req = 0, done = 0, irq = 0, pw = 0, osc, fbo, cen, pen, ram;
    logic [7:0] pd = 8'h00, sp, pc, po;
    pd_pkg::sfr_write_t wr = '0;
    wire logic rs;
    int error_cnt = 0, total_checks = 0, s = 30174, es = 7, ep = 255, ec = 0, m = 0;
    power_down_sequencer i_dut (.SYS_CLK(clk), .RESET(rst | rs), .SFR_WR(wr), .INSTR_DONE(done),
        .INTERRUPT(irq), .PORT_WR(pw), .PORT_WR_DATA(pd), .OSC_ENABLE(osc),
        .OSC_FEEDBACK_OPEN(fbo), .CPU_CLK_EN(cen), .PERIPH_CLK_EN(pen),
        .POWER_CONTROL(pc), .STACK_PTR(sp), .PORT_OUT(po), .RAM_RETAIN(ram));
    reset_src i_src (.SYS_CLK(clk), .REQ(req), .RESET(rs));
    initial forever #50 clk = ~clk;
    // Watchdog: the sequence needs about 140 cycles, the limit is 2000
    initial begin
        #200us;
        error_cnt++;
        report_and_stop();
    end
    function logic [7:0] rnd();
        s ^= s << 13;
        s ^= int'(unsigned'(s) >> 17);
        s ^= s << 5;
        return s[7:0];
    endfunction
    // Kind k: 0 write, 1 port, 2 interrupt, 3 none, 4 reset; model frozen in power-down
    task op(input logic [7:0] ad, dt, input int k);
        @(posedge clk);
        wr <= '{k == 0, ad, dt};
        {done, pw, irq, req} <= {k == 0, k == 1, k == 2, k == 4};
        pd <= dt;
        @(posedge clk);
        wr <= '0;
        {done, pw, irq, req} <= 4'h0;
        if (m != 3) begin
            if (k == 1) ep = dt;
            if (k == 0 && ad == 8'h81) es = dt;
            if (k == 0 && ad == 8'h87) ec = dt;
            if (k == 2) ec[0] = 0;
            m = ec[1] ? 3 : ec[0];
        end
        @(negedge clk);
        total_checks++;
        if (!(po === ep[7:0] && sp === es[7:0] && pc === ec[7:0] && ram === 1'h1
              && osc === (m != 3) && fbo === (m == 3) && cen === (m == 0) && pen === (m != 3))) begin
            error_cnt++;
            $display("unexpected at %0t: outputs differ", $time);
        end
    endtask
    task report_and_stop();
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        op(8'h00, 8'h00, 3);
        for (int i = 0; i < 2; i++) begin
            op(8'h00, rnd(), 1);
            op(8'h81, rnd(), 0);
            op(8'h87, 8'h01, 0);
            op(8'h00, 8'h00, 2);
            op(8'h87, 8'(2 + i), 0);
            op(8'h00, rnd(), 1);
            op(8'h81, rnd(), 0);
            op(8'h87, 8'h00, 0);
            op(8'h00, 8'h00, 2);
            op(8'h00, 8'h00, 4);
            repeat (42) @(posedge clk);
            ep = 255;
            es = 7;
            ec = 0;
            m = 0;
            op(8'h00, 8'h00, 3);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
